// file: verilog/field_dsp_pkg.sv
package field_dsp_pkg;

  // ==========================================================
  // Register addresses on the decoded command port
  localparam logic [3:0] ADDR_MODE       = 4'h0;
  localparam logic [3:0] ADDR_LIN_TC     = 4'h1;
  localparam logic [3:0] ADDR_QUAD_TC    = 4'h2;
  localparam logic [3:0] ADDR_GAIN       = 4'h3;
  localparam logic [3:0] ADDR_OFFSET     = 4'h4;
  localparam logic [3:0] ADDR_CLAMP_LOW  = 4'h5;
  localparam logic [3:0] ADDR_CLAMP_HIGH = 4'h6;
  localparam logic [3:0] ADDR_LOCK       = 4'h7;
  localparam logic [3:0] ADDR_RAW        = 4'h8;

  // ==========================================================
  // Field widths and positions
  localparam int CMD_ADDR_W   = 4;
  localparam int CMD_DATA_W   = 16;
  localparam int MODE_W       = 6;
  localparam int RANGE_LSB    = 0;
  localparam int FILTER_LSB   = 3;
  localparam int SEL_W        = 3;
  localparam int RAW_W        = 14;
  localparam int GAIN_W       = 14;
  localparam int GAIN_FRAC    = 11;
  localparam int OFFSET_W     = 11;
  localparam int CLAMP_LOW_W  = 11;
  localparam int CLAMP_HIGH_W = 12;
  localparam int OUT_W        = 12;
  localparam int SUM_W        = 18;
  localparam int TC_W         = 8;
  localparam int RANGE_MT_W   = 8;
  localparam int CORNER_HZ_W  = 12;

  // ==========================================================
  // Reset values
  localparam logic [MODE_W-1:0]       MODE_RST       = 6'h00;
  localparam logic [TC_W-1:0]         TC_RST         = 8'h00;
  localparam logic [GAIN_W-1:0]       GAIN_RST       = 14'h0800;
  localparam logic [OFFSET_W-1:0]     OFFSET_RST     = 11'h000;
  localparam logic [CLAMP_LOW_W-1:0]  CLAMP_LOW_RST  = 11'h000;
  localparam logic [CLAMP_HIGH_W-1:0] CLAMP_HIGH_RST = 12'h800;

  // Full supply in output steps
  localparam logic [SUM_W-1:0] FULL_SUPPLY = 18'h00800;

endpackage

// file: verilog/signal_conditioner.sv
`timescale 1ns/100ps
module signal_conditioner #(
  parameter int RAW_W        = field_dsp_pkg::RAW_W,
  parameter int GAIN_W       = field_dsp_pkg::GAIN_W,
  parameter int OFFSET_W     = field_dsp_pkg::OFFSET_W,
  parameter int CLAMP_LOW_W  = field_dsp_pkg::CLAMP_LOW_W,
  parameter int CLAMP_HIGH_W = field_dsp_pkg::CLAMP_HIGH_W,
  parameter int OUT_W        = field_dsp_pkg::OUT_W
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    sampleValid,
  input  wire logic [RAW_W-1:0]        sampleRaw,
  input  wire logic [GAIN_W-1:0]       gain,
  input  wire logic [OFFSET_W-1:0]     offset,
  input  wire logic [CLAMP_LOW_W-1:0]  clampLow,
  input  wire logic [CLAMP_HIGH_W-1:0] clampHigh,
  output logic      [OUT_W-1:0]        outCode_q,
  output logic                         outValid_q
);

  localparam int PROD_W = RAW_W + GAIN_W;
  localparam int SUM_W  = field_dsp_pkg::SUM_W;
  localparam int FRAC   = field_dsp_pkg::GAIN_FRAC;

  logic signed [PROD_W-1:0] product;
  logic signed [SUM_W-1:0]  scaled;
  logic signed [SUM_W-1:0]  offsetExt;
  logic signed [SUM_W-1:0]  sum;
  logic signed [SUM_W-1:0]  topLimit;
  logic signed [SUM_W-1:0]  highLimit;
  logic signed [SUM_W-1:0]  lowLimit;
  logic signed [SUM_W-1:0]  limited;
  logic signed [SUM_W-1:0]  result;

  // ==========================================================
  // Multiply, add, limit
  always_comb begin
    product   = $signed(sampleRaw) * $signed(gain);
    scaled    = SUM_W'(product >>> FRAC);
    offsetExt = SUM_W'($signed({offset, 1'b0}));
    sum       = scaled + offsetExt;
    topLimit  = offset[OFFSET_W-1] ? offsetExt + $signed(field_dsp_pkg::FULL_SUPPLY)
                                   : $signed(field_dsp_pkg::FULL_SUPPLY);
    highLimit = $signed(SUM_W'(clampHigh));
    lowLimit  = $signed(SUM_W'(clampLow));
    limited   = (sum > topLimit) ? topLimit : sum;
    if (limited > highLimit) begin
      limited = highLimit;
    end
    result = (limited < lowLimit) ? lowLimit : limited;
  end

  // ==========================================================
  // One output code per valid input sample
  always_ff @(posedge mclk) begin
    if (rst) begin
      outCode_q  <= '0;
      outValid_q <= 1'b0;
    end else begin
      outValid_q <= sampleValid;
      if (sampleValid) begin
        outCode_q <= result[OUT_W-1:0];
      end
    end
  end

endmodule

// file: verilog/field_signal_conditioning_dsp.sv
`timescale 1ns/100ps
module field_signal_conditioning_dsp #(
  parameter int CMD_ADDR_W = field_dsp_pkg::CMD_ADDR_W,
  parameter int CMD_DATA_W = field_dsp_pkg::CMD_DATA_W,
  parameter int TC_W       = field_dsp_pkg::TC_W
) (
  input  wire logic                                   mclk,
  input  wire logic                                   rst,
  input  wire logic                                   cmdValid,
  input  wire logic                                   cmdWrite,
  input  wire logic [CMD_ADDR_W-1:0]                  cmdAddr,
  input  wire logic [CMD_DATA_W-1:0]                  cmdData,
  input  wire logic                                   sampleValid,
  input  wire logic [field_dsp_pkg::RAW_W-1:0]        sampleRaw,
  input  wire logic                                   lockNvIn,
  output logic                                        replyValid_q,
  output logic      [CMD_DATA_W-1:0]                  replyData_q,
  output logic                                        analogOff_q,
  output logic                                        lockNvSet_q,
  output logic                                        lockActive_q,
  output logic      [field_dsp_pkg::SEL_W-1:0]        rangeSel_q,
  output logic      [field_dsp_pkg::RANGE_MT_W-1:0]   rangeMt_q,
  output logic      [field_dsp_pkg::SEL_W-1:0]        cornerSel_q,
  output logic      [field_dsp_pkg::CORNER_HZ_W-1:0]  cornerHz_q,
  output logic      [TC_W-1:0]                        linearTempCoeff_q,
  output logic      [TC_W-1:0]                        quadraticTempCoeff_q,
  output logic      [field_dsp_pkg::OUT_W-1:0]        outCode_q,
  output logic                                        outValid_q
);

  localparam int SEL_W = field_dsp_pkg::SEL_W;

  logic [field_dsp_pkg::MODE_W-1:0]       mode_q;
  logic [field_dsp_pkg::GAIN_W-1:0]       gain_q;
  logic [field_dsp_pkg::OFFSET_W-1:0]     quiescentOffset_q;
  logic [field_dsp_pkg::CLAMP_LOW_W-1:0]  clampLow_q;
  logic [field_dsp_pkg::CLAMP_HIGH_W-1:0] clampHigh_q;
  logic [field_dsp_pkg::RAW_W-1:0]        rawSample_q;
  logic                                   started_q;
  logic                                   cmdTaken;
  logic                                   cmdWr;
  logic [CMD_DATA_W-1:0]                  readData;

  // ==========================================================
  // Mode decoding
  function automatic logic [field_dsp_pkg::RANGE_MT_W-1:0] rangeMillitesla(input logic [SEL_W-1:0] code);
    unique case (code)
      3'h0: rangeMillitesla = 8'h1E;
      3'h4: rangeMillitesla = 8'h28;
      3'h5: rangeMillitesla = 8'h3C;
      3'h1: rangeMillitesla = 8'h4B;
      3'h6: rangeMillitesla = 8'h50;
      3'h2: rangeMillitesla = 8'h5A;
      3'h7: rangeMillitesla = 8'h64;
      3'h3: rangeMillitesla = 8'h96;
    endcase
  endfunction

  function automatic logic [field_dsp_pkg::CORNER_HZ_W-1:0] cornerHertz(input logic [SEL_W-1:0] code);
    unique case (code)
      3'h0:    cornerHertz = 12'h050;
      3'h1:    cornerHertz = 12'h0A0;
      3'h2:    cornerHertz = 12'h1F4;
      3'h3:    cornerHertz = 12'h3E8;
      3'h4:    cornerHertz = 12'h7D0;
      default: cornerHertz = 12'h000;
    endcase
  endfunction

  // ==========================================================
  // Lock capture after power-on release
  always_ff @(posedge mclk) begin
    if (rst) begin
      started_q    <= 1'b0;
      lockActive_q <= 1'b0;
    end else if (!started_q) begin
      started_q    <= 1'b1;
      lockActive_q <= lockNvIn;
    end
  end

  assign cmdTaken = cmdValid && started_q && !lockActive_q;
  assign cmdWr    = cmdTaken && cmdWrite;

  always_ff @(posedge mclk) begin
    if (rst) begin
      lockNvSet_q <= 1'b0;
    end else if (!started_q) begin
      lockNvSet_q <= lockNvIn;
    end else if (cmdWr && cmdAddr == field_dsp_pkg::ADDR_LOCK && cmdData[0]) begin
      lockNvSet_q <= 1'b1;
    end
  end

  // ==========================================================
  // Settings writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q               <= field_dsp_pkg::MODE_RST;
      linearTempCoeff_q    <= field_dsp_pkg::TC_RST;
      quadraticTempCoeff_q <= field_dsp_pkg::TC_RST;
      gain_q               <= field_dsp_pkg::GAIN_RST;
      quiescentOffset_q    <= field_dsp_pkg::OFFSET_RST;
      clampLow_q           <= field_dsp_pkg::CLAMP_LOW_RST;
      clampHigh_q          <= field_dsp_pkg::CLAMP_HIGH_RST;
    end else if (cmdWr) begin
      unique case (cmdAddr)
        field_dsp_pkg::ADDR_MODE:       mode_q               <= cmdData[field_dsp_pkg::MODE_W-1:0];
        field_dsp_pkg::ADDR_LIN_TC:     linearTempCoeff_q    <= cmdData[TC_W-1:0];
        field_dsp_pkg::ADDR_QUAD_TC:    quadraticTempCoeff_q <= cmdData[TC_W-1:0];
        field_dsp_pkg::ADDR_GAIN:       gain_q               <= cmdData[field_dsp_pkg::GAIN_W-1:0];
        field_dsp_pkg::ADDR_OFFSET:     quiescentOffset_q    <= cmdData[field_dsp_pkg::OFFSET_W-1:0];
        field_dsp_pkg::ADDR_CLAMP_LOW: begin
          if (cmdData[field_dsp_pkg::CLAMP_LOW_W-1]) begin
            clampLow_q <= {1'b1, {(field_dsp_pkg::CLAMP_LOW_W-1){1'b0}}};
          end else begin
            clampLow_q <= cmdData[field_dsp_pkg::CLAMP_LOW_W-1:0];
          end
        end
        field_dsp_pkg::ADDR_CLAMP_HIGH: begin
          if (cmdData[field_dsp_pkg::CLAMP_HIGH_W-1]) begin
            clampHigh_q <= {1'b1, {(field_dsp_pkg::CLAMP_HIGH_W-1){1'b0}}};
          end else begin
            clampHigh_q <= cmdData[field_dsp_pkg::CLAMP_HIGH_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Mode outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      rangeSel_q  <= '0;
      rangeMt_q   <= '0;
      cornerSel_q <= '0;
      cornerHz_q  <= '0;
    end else begin
      rangeSel_q  <= mode_q[field_dsp_pkg::RANGE_LSB +: SEL_W];
      rangeMt_q   <= rangeMillitesla(mode_q[field_dsp_pkg::RANGE_LSB +: SEL_W]);
      cornerSel_q <= mode_q[field_dsp_pkg::FILTER_LSB +: SEL_W];
      cornerHz_q  <= cornerHertz(mode_q[field_dsp_pkg::FILTER_LSB +: SEL_W]);
    end
  end

  // ==========================================================
  // Raw sample capture, sign kept as delivered
  always_ff @(posedge mclk) begin
    if (rst) begin
      rawSample_q <= '0;
    end else if (sampleValid) begin
      rawSample_q <= sampleRaw;
    end
  end

  // ==========================================================
  // Read answers
  always_comb begin
    readData = '0;
    unique case (cmdAddr)
      field_dsp_pkg::ADDR_MODE:       readData = CMD_DATA_W'(mode_q);
      field_dsp_pkg::ADDR_LIN_TC:     readData = CMD_DATA_W'(linearTempCoeff_q);
      field_dsp_pkg::ADDR_QUAD_TC:    readData = CMD_DATA_W'(quadraticTempCoeff_q);
      field_dsp_pkg::ADDR_GAIN:       readData = CMD_DATA_W'(gain_q);
      field_dsp_pkg::ADDR_OFFSET:     readData = CMD_DATA_W'(quiescentOffset_q);
      field_dsp_pkg::ADDR_CLAMP_LOW:  readData = CMD_DATA_W'(clampLow_q);
      field_dsp_pkg::ADDR_CLAMP_HIGH: readData = CMD_DATA_W'(clampHigh_q);
      field_dsp_pkg::ADDR_LOCK:       readData = CMD_DATA_W'(lockNvSet_q);
      field_dsp_pkg::ADDR_RAW:        readData = CMD_DATA_W'(rawSample_q);
      default:                        readData = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      replyValid_q <= 1'b0;
      replyData_q  <= '0;
      analogOff_q  <= 1'b0;
    end else begin
      replyValid_q <= cmdTaken && !cmdWrite;
      analogOff_q  <= cmdTaken;
      if (cmdTaken && !cmdWrite) begin
        replyData_q <= readData;
      end
    end
  end

  // ==========================================================
  // Conditioning datapath
  signal_conditioner u_conditioner (
    .mclk        (mclk),
    .rst         (rst),
    .sampleValid (sampleValid),
    .sampleRaw   (sampleRaw),
    .gain        (gain_q),
    .offset      (quiescentOffset_q),
    .clampLow    (clampLow_q),
    .clampHigh   (clampHigh_q),
    .outCode_q   (outCode_q),
    .outValid_q  (outValid_q)
  );

endmodule

// file: verif/field_dsp_properties.sv
`timescale 1ns/100ps
module field_dsp_properties #(
  parameter int CMD_ADDR_W = 4,
  parameter int CMD_DATA_W = 16
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  cmdValid,
  input wire logic                  cmdWrite,
  input wire logic [CMD_ADDR_W-1:0] cmdAddr,
  input wire logic [CMD_DATA_W-1:0] cmdData,
  input wire logic                  sampleValid,
  input wire logic                  replyValid_q,
  input wire logic                  analogOff_q,
  input wire logic                  lockNvSet_q,
  input wire logic                  lockActive_q,
  input wire logic [2:0]            rangeSel_q,
  input wire logic [7:0]            rangeMt_q,
  input wire logic [11:0]           outCode_q,
  input wire logic                  outValid_q
);
  localparam logic [7:0] MT [8] = '{8'h1E, 8'h4B, 8'h5A, 8'h96, 8'h28, 8'h3C, 8'h50, 8'h64};
  logic live_q;
  logic taken;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Commands count only from the second edge after release
  always_ff @(posedge mclk) begin
    live_q <= !rst;
  end
  assign taken = cmdValid && live_q && !lockActive_q;
  sequence sRead;
    taken && !cmdWrite;
  endsequence
  sequence sAnswer;
    replyValid_q && analogOff_q;
  endsequence
  sequence sModeWr;
    taken && cmdWrite && cmdAddr == field_dsp_pkg::ADDR_MODE;
  endsequence
  a_read_answer: assert property (sRead |=> sAnswer)
    else $error("read not answered next cycle");
  a_write_silent: assert property (taken && cmdWrite |=> analogOff_q && !replyValid_q)
    else $error("write gave a reply or no analog off");
  a_lock_mute: assert property (lockActive_q |=> !replyValid_q && !analogOff_q)
    else $error("locked device answered");
  a_off_cause: assert property (analogOff_q |-> $past(taken))
    else $error("analog off without a command");
  a_lock_frozen: assert property (live_q |=> $stable(lockActive_q))
    else $error("lock state changed without power cycle");
  a_lock_sticky: assert property (lockNvSet_q |=> lockNvSet_q)
    else $error("stored lock cleared");
  a_lock_store: assert property (taken && cmdWrite && cmdAddr == field_dsp_pkg::ADDR_LOCK && cmdData[0]
    |=> lockNvSet_q)
    else $error("lock write not stored");
  a_out_pulse: assert property (sampleValid |=> outValid_q)
    else $error("no output one cycle after sample");
  a_out_hold: assert property (!outValid_q |-> $stable(outCode_q))
    else $error("output moved between samples");
  a_mode_range: assert property (sModeWr |-> ##2 (rangeSel_q == $past(cmdData[2:0], 2)
    && rangeMt_q == MT[rangeSel_q]))
    else $error("range code or range value wrong");
endmodule

bind field_signal_conditioning_dsp field_dsp_properties #(.CMD_ADDR_W(CMD_ADDR_W), .CMD_DATA_W(CMD_DATA_W))
  u_props (
    .mclk         (mclk),
    .rst          (rst),
    .cmdValid     (cmdValid),
    .cmdWrite     (cmdWrite),
    .cmdAddr      (cmdAddr),
    .cmdData      (cmdData),
    .sampleValid  (sampleValid),
    .replyValid_q (replyValid_q),
    .analogOff_q  (analogOff_q),
    .lockNvSet_q  (lockNvSet_q),
    .lockActive_q (lockActive_q),
    .rangeSel_q   (rangeSel_q),
    .rangeMt_q    (rangeMt_q),
    .outCode_q    (outCode_q),
    .outValid_q   (outValid_q)
  );

// file: verif/supply_programmer.sv
`timescale 1ns/100ps
module supply_programmer (
  input  wire logic        mclk,
  input  wire logic        replyValid_q,
  input  wire logic [15:0] replyData_q,
  input  wire logic        analogOff_q,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [3:0]       cmdAddr,
  output logic [15:0]      cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 4'h0;
    cmdData = 16'h0000;
  end
  // ==========================================================
  // One telegram; released address and data lines show the inverse of the last value
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
                      output logic rv, output logic off, output logic [15:0] rd);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmdAddr <= ~a;
    cmdData <= ~d;
    @(posedge mclk);
    rv = replyValid_q;
    off = analogOff_q;
    rd = replyData_q;
  endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        sampleValid = 1'b0;
  logic [13:0] sampleRaw = 14'h0000;
  logic        lockNvIn = 1'b0;
  logic        lk = 1'b0;
  logic        cmdValid, cmdWrite, replyValid_q, analogOff_q, lockNvSet_q, lockActive_q, outValid_q;
  logic [3:0]  cmdAddr;
  logic [15:0] cmdData, replyData_q, lastRd;
  logic [11:0] cornerHz_q, outCode_q;
  logic [2:0]  cornerSel_q;
  logic [7:0]  linTc, quadTc;
  int          errCount = 0;
  int          testsRun = 0;
  localparam logic [15:0] RV [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0800, 16'h0000, 16'h0000, 16'h0800, 16'h0000};
  localparam logic [11:0] HZ [8] = '{12'h050, 12'h0A0, 12'h1F4, 12'h3E8, 12'h7D0, 12'h000, 12'h000, 12'h000};
  always #20 mclk = ~mclk;
  field_signal_conditioning_dsp u_dut (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .sampleValid(sampleValid), .sampleRaw(sampleRaw), .lockNvIn(lockNvIn),
    .replyValid_q(replyValid_q), .replyData_q(replyData_q), .analogOff_q(analogOff_q), .lockNvSet_q(lockNvSet_q),
    .lockActive_q(lockActive_q), .rangeSel_q(), .rangeMt_q(), .cornerSel_q(cornerSel_q), .cornerHz_q(cornerHz_q),
    .linearTempCoeff_q(linTc), .quadraticTempCoeff_q(quadTc), .outCode_q(outCode_q), .outValid_q(outValid_q));
  supply_programmer u_prog (.mclk(mclk), .replyValid_q(replyValid_q), .replyData_q(replyData_q),
    .analogOff_q(analogOff_q), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData));
  // ==========================================================
  // Access tasks and output model
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic rv, off;
    logic [15:0] rdat;
    u_prog.xfer(1'b1, a, d, rv, off, rdat);
    `CHK("write answer", {1'b0, !lk}, {rv, off})
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic rv, off;
    u_prog.xfer(1'b0, a, 16'h0000, rv, off, lastRd);
    `CHK("read answer", {!lk, !lk}, {rv, off})
    if (!lk) `CHK("read data", exp, lastRd)
  endtask
  task automatic smp(input logic [13:0] s, input logic [11:0] exp);
    @(posedge mclk);
    sampleValid <= 1'b1;
    sampleRaw <= s;
    @(posedge mclk);
    sampleValid <= 1'b0;
    sampleRaw <= ~s;
    @(posedge mclk);
    `CHK("out code", {1'b1, exp}, {outValid_q, outCode_q})
  endtask
  function automatic logic [11:0] f(int s, int g, int o, int lo, int hi);
    int v;
    v = ((s * g) >>> 11) + 2 * o;
    if (o < 0 && v > 2 * o + 2048) v = 2 * o + 2048;
    if (v > hi) v = hi;
    if (v < lo) v = lo;
    return v[11:0];
  endfunction
  task automatic dp(int g, int o, int lo, int hi, int s);
    wr(field_dsp_pkg::ADDR_GAIN, 16'(g));
    wr(field_dsp_pkg::ADDR_OFFSET, 16'(o));
    wr(field_dsp_pkg::ADDR_CLAMP_LOW, 16'(lo));
    wr(field_dsp_pkg::ADDR_CLAMP_HIGH, 16'(hi));
    smp(14'(s), f(s, g, o, lo > 1023 ? 1024 : lo, hi > 2047 ? 2048 : hi));
  endtask
  task automatic powerCycle();
    @(posedge mclk);
    lockNvIn <= (lockNvSet_q === 1'b1);
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic conclude();
    if (errCount == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int r1, r2, g, o;
    powerCycle();
    for (int i = 0; i < 8; i++) rd(4'(i), RV[i]);
    rd(4'hF, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(field_dsp_pkg::ADDR_MODE, 16'(i * 9));
      @(posedge mclk);
      `CHK("corner", {3'(i), HZ[i]}, {cornerSel_q, cornerHz_q})
      rd(field_dsp_pkg::ADDR_MODE, 16'(i * 9));
    end
    wr(field_dsp_pkg::ADDR_LIN_TC, 16'h015A);
    wr(field_dsp_pkg::ADDR_QUAD_TC, 16'h00A5);
    `CHK("temp coeffs", 16'h5AA5, {linTc, quadTc})
    rd(field_dsp_pkg::ADDR_LIN_TC, 16'h005A);
    dp(2048, 0, 0, 2048, 1000);
    dp(-8192, 0, 0, 2048, -1000);
    dp(2048, -512, 0, 2048, 8191);
    dp(2048, 0, 256, 2048, -8192);
    dp(1, 0, 0, 2048, 4000);
    dp(2048, 511, 0, 4095, 8191);
    dp(2048, 100, 2000, 512, 0);
    dp(2048, 0, 0, 2048, -5);
    rd(field_dsp_pkg::ADDR_RAW, 16'h3FFB);
    wr(field_dsp_pkg::ADDR_RAW, 16'h0000);
    rd(field_dsp_pkg::ADDR_RAW, 16'h3FFB);
    dp(2048, 0, 0, 2048, -1000);
    rd(field_dsp_pkg::ADDR_RAW, 16'h3C18);
    r1 = int'($signed(lastRd[13:0]));
    dp(2048, 0, 0, 2048, 1000);
    rd(field_dsp_pkg::ADDR_RAW, 16'h03E8);
    r2 = int'($signed(lastRd[13:0]));
    g = (1843 - 205) * 2048 / (r1 - r2);
    o = (1843 - r1 * g / 2048) / 2;
    dp(g, o, 0, 2048, r1);
    `CHK("calibrated", 1'b1, outCode_q > 12'h731 && outCode_q < 12'h736)
    wr(field_dsp_pkg::ADDR_LOCK, 16'h0001);
    `CHK("lock stored", 1'b1, lockNvSet_q)
    wr(field_dsp_pkg::ADDR_LOCK, 16'h0000);
    rd(field_dsp_pkg::ADDR_LOCK, 16'h0001);
    `CHK("lock early", 1'b0, lockActive_q)
    powerCycle();
    lk = 1'b1;
    `CHK("lock state", 2'b11, {lockActive_q, lockNvSet_q})
    wr(field_dsp_pkg::ADDR_GAIN, 16'h0400);
    rd(field_dsp_pkg::ADDR_RAW, 16'h0000);
    smp(14'h03E8, 12'h3E8);
    conclude();
  end
endmodule
